// ===== logic/ppkc_pkg.sv
// package for the pad pull and keeper control register
// assumes a 32-bit apb slave with word-aligned registers
package ppkc_pkg;
    localparam logic [15:0] PPKC_CTRL_OFFSET = 16'h8800;
    localparam int PPKC_ADDR_WIDTH = 16;
    localparam int PPKC_CTRL_WIDTH = 8;
    localparam logic [7:0] PPKC_CTRL_RESET = 8'h00;
    localparam int PPKC_BIT_MEMIF_ADDRESS = 0;
    localparam int PPKC_BIT_MEMIF_DATA = 1;
    localparam int PPKC_BIT_MEMIF_CONTROL = 2;
    localparam int PPKC_BIT_HOST_DATA = 3;
    localparam int PPKC_BIT_HOST_CONTROL = 4;
    localparam int PPKC_BIT_INTERRUPT_WATCHDOG = 5;
    localparam int PPKC_BIT_TEST_PORT = 6;
    localparam int PPKC_BIT_EMULATION = 7;
endpackage : ppkc_pkg

// ===== logic/ppkc_top.sv
// apb register bank holding the pad pull / keeper disable bits
// assumes a single pclk domain; pad enables go straight to pad cells
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps

module ppkc_top import ppkc_pkg::*; #(
    parameter int ADDR_WIDTH = PPKC_ADDR_WIDTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic emulation_pull_enable,
    output logic test_port_pull_enable,
    output logic interrupt_watchdog_pull_enable,
    output logic host_control_pull_enable,
    output logic host_data_holder_enable,
    output logic memif_control_holder_enable,
    output logic memif_data_holder_enable,
    output logic memif_address_holder_enable
);

    // ------------------------------------------------------------
    // apb access
    // ------------------------------------------------------------
    // answer lands in the second access cycle; pready is a flop,
    // so access phase lasts two cycles
    logic [PPKC_CTRL_WIDTH-1:0] ctrl;
    logic [PPKC_CTRL_WIDTH-1:0] next_ctrl;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic hit;
    logic access;

    assign hit = (paddr == ADDR_WIDTH'(PPKC_CTRL_OFFSET));
    assign access = psel && penable && !pready;

    always_comb begin
        next_ctrl = ctrl;
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        if (access) begin
            next_pready = 1'b1;
            next_pslverr = !hit;
            next_prdata = 32'h0000_0000;
            if (hit && pwrite && pstrb[0]) begin
                next_ctrl = pwdata[PPKC_CTRL_WIDTH-1:0];
            end
            if (hit && !pwrite) begin
                // upper bits stay zero
                next_prdata = {24'h00_0000, ctrl};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= PPKC_CTRL_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // pad feature enables
    // ------------------------------------------------------------
    // no pin-function select enters here, so shared pins lose their keeper only when their control bit is written to 1
    logic [PPKC_CTRL_WIDTH-1:0] pad_en;
    logic [PPKC_CTRL_WIDTH-1:0] next_pad_en;

    always_comb begin
        next_pad_en = ~next_ctrl;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_en <= ~PPKC_CTRL_RESET;
        end else begin
            pad_en <= next_pad_en;
        end
    end

    assign emulation_pull_enable = pad_en[PPKC_BIT_EMULATION];
    assign test_port_pull_enable = pad_en[PPKC_BIT_TEST_PORT];
    assign interrupt_watchdog_pull_enable = pad_en[PPKC_BIT_INTERRUPT_WATCHDOG];
    assign host_control_pull_enable = pad_en[PPKC_BIT_HOST_CONTROL];
    assign host_data_holder_enable = pad_en[PPKC_BIT_HOST_DATA];
    assign memif_control_holder_enable = pad_en[PPKC_BIT_MEMIF_CONTROL];
    assign memif_data_holder_enable = pad_en[PPKC_BIT_MEMIF_DATA];
    assign memif_address_holder_enable = pad_en[PPKC_BIT_MEMIF_ADDRESS];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic wr_hit;
    assign wr_hit = access && hit && pwrite && pstrb[0];

    property p_emulation_follow;
        @(posedge pclk) disable iff (!presetn)
        wr_hit |=> emulation_pull_enable == !$past(pwdata[PPKC_BIT_EMULATION]);
    endproperty
    a_emulation_follow: assert property (p_emulation_follow) else $error("emulation enable wrong");

    property p_test_port_follow;
        @(posedge pclk) disable iff (!presetn)
        wr_hit |=> test_port_pull_enable == !$past(pwdata[PPKC_BIT_TEST_PORT]);
    endproperty
    a_test_port_follow: assert property (p_test_port_follow) else $error("test enable wrong");

    property p_watchdog_follow;
        @(posedge pclk) disable iff (!presetn)
        wr_hit |=> interrupt_watchdog_pull_enable == !$past(pwdata[PPKC_BIT_INTERRUPT_WATCHDOG]);
    endproperty
    a_watchdog_follow: assert property (p_watchdog_follow) else $error("watchdog enable wrong");

    property p_host_control_follow;
        @(posedge pclk) disable iff (!presetn)
        wr_hit |=> host_control_pull_enable == !$past(pwdata[PPKC_BIT_HOST_CONTROL]);
    endproperty
    a_host_control_follow: assert property (p_host_control_follow) else $error("host control enable wrong");

    property p_host_data_follow;
        @(posedge pclk) disable iff (!presetn)
        wr_hit |=> host_data_holder_enable == !$past(pwdata[PPKC_BIT_HOST_DATA]);
    endproperty
    a_host_data_follow: assert property (p_host_data_follow) else $error("host data enable wrong");

    property p_memif_control_follow;
        @(posedge pclk) disable iff (!presetn)
        wr_hit |=> memif_control_holder_enable == !$past(pwdata[PPKC_BIT_MEMIF_CONTROL]);
    endproperty
    a_memif_control_follow: assert property (p_memif_control_follow) else $error("control enable wrong");

    property p_memif_data_follow;
        @(posedge pclk) disable iff (!presetn)
        wr_hit |=> memif_data_holder_enable == !$past(pwdata[PPKC_BIT_MEMIF_DATA]);
    endproperty
    a_memif_data_follow: assert property (p_memif_data_follow) else $error("memif data enable wrong");

    property p_memif_address_follow;
        @(posedge pclk) disable iff (!presetn)
        wr_hit |=> memif_address_holder_enable == !$past(pwdata[PPKC_BIT_MEMIF_ADDRESS]);
    endproperty
    a_memif_address_follow: assert property (p_memif_address_follow) else $error("address enable wrong");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        (pready && !pslverr) |-> prdata[31:PPKC_CTRL_WIDTH] == 24'h00_0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    property p_read_back;
        @(posedge pclk) disable iff (!presetn)
        (access && hit && !pwrite) |=> prdata[PPKC_CTRL_WIDTH-1:0] == ~pad_en;
    endproperty
    a_read_back: assert property (p_read_back) else $error("read data differs from pad enables");

    property p_enable_inverse;
        @(posedge pclk) disable iff (!presetn)
        pad_en == ~ctrl;
    endproperty
    a_enable_inverse: assert property (p_enable_inverse) else $error("enables not inverse of bits");

    property p_hold_no_write;
        @(posedge pclk) disable iff (!presetn)
        !wr_hit |=> $stable(pad_en);
    endproperty
    a_hold_no_write: assert property (p_hold_no_write) else $error("enable moved without write");

    // ------------------------------------------------------------
    // bus protocol and register content checks
    // ------------------------------------------------------------
    // one access-phase edge is taken per transfer, so pready is a single pulse
    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");

    property p_ready_answer;
        @(posedge pclk) disable iff (!presetn)
        access |=> pready;
    endproperty
    a_ready_answer: assert property (p_ready_answer) else $error("no pready after access");

    property p_ready_idle;
        @(posedge pclk) disable iff (!presetn)
        !psel |=> !pready;
    endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("pready without select");

    property p_error_idle;
        @(posedge pclk) disable iff (!presetn)
        !psel |=> !pslverr;
    endproperty
    a_error_idle: assert property (p_error_idle) else $error("pslverr without select");

    property p_error_with_ready;
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready;
    endproperty
    a_error_with_ready: assert property (p_error_with_ready) else $error("pslverr without pready");

    property p_error_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (access && !hit) |=> pready && pslverr;
    endproperty
    a_error_unmapped: assert property (p_error_unmapped) else $error("unmapped access not flagged");

    property p_error_mapped;
        @(posedge pclk) disable iff (!presetn)
        (access && hit) |=> pready && !pslverr;
    endproperty
    a_error_mapped: assert property (p_error_mapped) else $error("mapped access flagged");

    property p_unmapped_no_write;
        @(posedge pclk) disable iff (!presetn)
        (access && !hit) |=> $stable(ctrl);
    endproperty
    a_unmapped_no_write: assert property (p_unmapped_no_write) else $error("unmapped access changed bits");

    property p_strobe_gate;
        @(posedge pclk) disable iff (!presetn)
        (access && hit && pwrite && !pstrb[0]) |=> $stable(ctrl);
    endproperty
    a_strobe_gate: assert property (p_strobe_gate) else $error("write without low strobe landed");

    property p_write_stores;
        @(posedge pclk) disable iff (!presetn)
        wr_hit |=> ctrl == $past(pwdata[PPKC_CTRL_WIDTH-1:0]);
    endproperty
    a_write_stores: assert property (p_write_stores) else $error("written bits not stored");

    property p_ctrl_hold;
        @(posedge pclk) disable iff (!presetn)
        !wr_hit |=> $stable(ctrl);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("bits moved without write");

    property p_read_value;
        @(posedge pclk) disable iff (!presetn)
        (access && hit && !pwrite) |=> prdata == 32'($past(ctrl));
    endproperty
    a_read_value: assert property (p_read_value) else $error("read data differs from bits");

    property p_read_unmapped_zero;
        @(posedge pclk) disable iff (!presetn)
        (access && !hit) |=> prdata == 32'h0000_0000;
    endproperty
    a_read_unmapped_zero: assert property (p_read_unmapped_zero) else $error("unmapped read not zero");

    property p_read_no_change;
        @(posedge pclk) disable iff (!presetn)
        (access && !pwrite) |=> $stable(pad_en);
    endproperty
    a_read_no_change: assert property (p_read_no_change) else $error("read moved an enable");

    property p_emulation_untouched;
        @(posedge pclk) disable iff (!presetn)
        (wr_hit && pwdata[PPKC_BIT_EMULATION] == ctrl[PPKC_BIT_EMULATION]) |=> $stable(emulation_pull_enable);
    endproperty
    a_emulation_untouched: assert property (p_emulation_untouched) else $error("emulation enable disturbed");

    // ------------------------------------------------------------
    // reset checks
    // ------------------------------------------------------------
    // first edge after release: flops still show their reset values
    property p_reset_ctrl;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> ctrl == PPKC_CTRL_RESET;
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("bits not cleared by reset");

    property p_reset_enables;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> pad_en == ~PPKC_CTRL_RESET;
    endproperty
    a_reset_enables: assert property (p_reset_enables) else $error("enables not on after reset");

    property p_reset_bus;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> !pready && !pslverr && prdata == 32'h0000_0000;
    endproperty
    a_reset_bus: assert property (p_reset_bus) else $error("bus outputs not idle after reset");

endmodule : ppkc_top

// ===== bench/ppkc_tb.sv
// self-checking bench for the pad pull and keeper control register
// assumes ppkc_top alone, driven over apb by this bench with an integer model
`timescale 1ns/1ps
module testbench import ppkc_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    wire [7:0] en_bus;
    logic [7:0] en_cap;
    int bad_count = 0;
    int n_compared = 0;

    always #4 pclk = ~pclk;

    ppkc_top #(.ADDR_WIDTH(16)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .emulation_pull_enable(en_bus[7]), .test_port_pull_enable(en_bus[6]),
        .interrupt_watchdog_pull_enable(en_bus[5]), .host_control_pull_enable(en_bus[4]),
        .host_data_holder_enable(en_bus[3]), .memif_control_holder_enable(en_bus[2]),
        .memif_data_holder_enable(en_bus[1]), .memif_address_holder_enable(en_bus[0]));

    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // entered just after a rising edge; psel stays up so calls may run back to back
    task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] r, output logic e);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // pready is read before this edge's updates land, as a flop would see it
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            bad_count++;
            $display("CHECK FAILED at %0t: no pready", $time);
            stop_test();
        end
        r = prdata;
        e = pslverr;
        en_cap = en_bus;
    endtask : apb

    initial begin
        int m;
        logic [31:0] r;
        logic [31:0] d;
        logic [15:0] a;
        logic [3:0] s;
        logic e;
        logic w;
        void'($urandom(73400));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({24'h0, en_bus}, 32'h000000ff);
        m = 0;
        apb(PPKC_CTRL_OFFSET, 1'b0, 32'h0, 4'h0, r, e);
        chk(r, 32'h0);
        // walking one, upper bits filled with noise that must be dropped
        for (int i = 0; i < 8; i++) begin
            d = ($urandom() & 32'hffffff00) | (32'h1 << i);
            apb(PPKC_CTRL_OFFSET, 1'b1, d, 4'hf, r, e);
            chk({24'h0, en_cap}, ~(32'h1 << i) & 32'hff);
            apb(PPKC_CTRL_OFFSET, 1'b0, 32'h0, 4'h0, r, e);
            chk(r, 32'h1 << i);
            m = 1 << i;
        end
        // random mix of mapped and unmapped reads and writes, odd strobes
        repeat (40) begin
            a = ($urandom() % 2 == 0) ? PPKC_CTRL_OFFSET : 16'($urandom() & 32'hfffc);
            w = 1'($urandom());
            d = $urandom();
            s = w ? 4'($urandom()) : 4'h0;
            if (w && a == PPKC_CTRL_OFFSET && s[0]) m = d & 255;
            apb(a, w, d, s, r, e);
            chk({31'h0, e}, {31'h0, a != PPKC_CTRL_OFFSET});
            if (!w) chk(r, (a == PPKC_CTRL_OFFSET) ? 32'(m) : 32'h0);
            chk({24'h0, en_cap}, ~32'(m) & 32'hff);
        end
        // leave a known pattern, low strobe only, so the reset below has work to do
        apb(PPKC_CTRL_OFFSET, 1'b1, 32'h0000_005a, 4'h1, r, e);
        chk({24'h0, en_cap}, 32'h0000_00a5);
        psel <= 1'b0;
        penable <= 1'b0;
        // second reset in mid-run must bring every feature back on
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({24'h0, en_bus}, 32'h000000ff);
        apb(PPKC_CTRL_OFFSET, 1'b0, 32'h0, 4'h0, r, e);
        chk(r, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
        stop_test();
    end
endmodule : testbench
